// [design/pad_driver.sv]
// turns a pin request into pad level, enable and pull-up
`timescale 1ns/100ps
module pad_driver (
	pad_req_if.dst req,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pullup
);
	// open drain only ever pulls low; pull-up is off while anything drives
	always_comb begin
		pad_out = 1'b0;
		pad_oe = 1'b0;
		pad_pullup = 1'b0;
		case (req.func)
			port_b_pkg::FUNC_PORT_OUT: begin
				if (req.open_drain) begin
					pad_oe = ~req.level; // [R04]
				end else begin
					pad_out = req.level; // [R05]
					pad_oe = 1'b1;
				end
			end
			port_b_pkg::FUNC_TIMER_OUT,
			port_b_pkg::FUNC_MOTOR_OUT: begin
				pad_out = req.level; // [R14]
				pad_oe = 1'b1; // [R17]
			end
			port_b_pkg::FUNC_PORT_IN,
			port_b_pkg::FUNC_MOTOR_IN: begin
				pad_pullup = req.pullup_bit; // [R02]
			end
			default: begin
				pad_oe = 1'b0;
			end
		endcase
	end
endmodule

// [design/pin_select.sv]
// priority mux that picks one pin's function
`timescale 1ns/100ps
module pin_select (
	input wire logic motor_enable,
	input wire logic motor_level,
	input wire logic motor_input_enable,
	input wire logic timer_out_mode,
	input wire logic timer_level,
	input wire logic direction,
	input wire logic output_data,
	input wire logic output_type,
	input wire logic pullup_enable,
	pad_req_if.src req
);
	// motor timer first, pulse timer next, port direction last
	always_comb begin
		req.open_drain = 1'b0;
		req.pullup_bit = pullup_enable;
		req.level = 1'b0;
		if (motor_enable) begin
			req.func = port_b_pkg::FUNC_MOTOR_OUT; // [R06] [R07] [R08] [R09] [R10] [R11] [R12]
			req.level = motor_level;
		end else if (motor_input_enable && !direction) begin
			req.func = port_b_pkg::FUNC_MOTOR_IN; // [R13]
		end else if (timer_out_mode) begin
			// compare output overrides the direction bit
			req.func = port_b_pkg::FUNC_TIMER_OUT; // [R14]
			req.level = timer_level;
		end else if (direction) begin
			req.func = port_b_pkg::FUNC_PORT_OUT; // [R15]
			req.level = output_data;
			req.open_drain = output_type;
		end else begin
			req.func = port_b_pkg::FUNC_PORT_IN; // [R15]
		end
	end
endmodule

// [design/port_b_pad_control_mux.sv]
// port b pad control: apb registers, pin function mux and pad outputs
//
// How it works
// R01: an 8-bit read/write pull-up register, one bit per pin, resets to zero.
// R02: a pin used as port input gets its pull-up when its pull-up bit is one.
// R03: an 8-bit read/write output-type register, one bit per pin, resets to zero.
// R04: a port output with output-type one drives open-drain and has no pull-up.
// R05: a port output with output-type zero drives push-pull.
// R06: pin 7 takes motor b-phase out 2, else channel 5 b compare, else the port.
// R07: pin 6 takes motor a-phase out 2, else channel 5 a compare, else the port.
// R08: pin 5 takes motor b-phase out 1, else channel 4 b compare, else the port.
// R09: pin 4 takes motor a-phase out 1, else channel 4 a compare, else the port.
// R10: pin 3 takes motor b-phase out 0, else channel 3 d compare, else the port.
// R11: pin 2 takes motor a-phase out 0, else channel 3 c compare, else the port.
// R12: pin 1 takes motor auxiliary out, else channel 3 b compare, else the port.
// R13: pin 0 feeds the motor auxiliary input when enabled with direction zero.
// R14: a timer compare output drives its pin whatever the direction bit says; on pin 0 an enabled auxiliary input wins at direction zero.
// R15: direction one makes a port output, zero an input; it is write-only, resets zero.
// R16: the pin-state read gives output data where direction is one, pin level else.
// R17: the pull-up is off whenever the port or a timer drives the pin.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "port_b_defines.svh"
module port_b_pad_control_mux #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pads
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output logic [7:0] pad_pullup,
	// motor timer enables and levels
	input wire logic motor_b_phase_out2_enable,
	input wire logic motor_a_phase_out2_enable,
	input wire logic motor_b_phase_out1_enable,
	input wire logic motor_a_phase_out1_enable,
	input wire logic motor_b_phase_out0_enable,
	input wire logic motor_a_phase_out0_enable,
	input wire logic motor_aux_output_enable,
	input wire logic motor_aux_input_enable,
	input wire logic motor_b_phase_out2,
	input wire logic motor_a_phase_out2,
	input wire logic motor_b_phase_out1,
	input wire logic motor_a_phase_out1,
	input wire logic motor_b_phase_out0,
	input wire logic motor_a_phase_out0,
	input wire logic motor_aux_output,
	output logic motor_aux_input,
	// pulse timer compare modes and levels
	input wire logic timer_ch5_io_b_out_mode,
	input wire logic timer_ch5_io_a_out_mode,
	input wire logic timer_ch4_io_b_out_mode,
	input wire logic timer_ch4_io_a_out_mode,
	input wire logic timer_ch3_io_d_out_mode,
	input wire logic timer_ch3_io_c_out_mode,
	input wire logic timer_ch3_io_b_out_mode,
	input wire logic timer_ch3_io_a_out_mode,
	input wire logic timer_ch5_io_b_out,
	input wire logic timer_ch5_io_a_out,
	input wire logic timer_ch4_io_b_out,
	input wire logic timer_ch4_io_a_out,
	input wire logic timer_ch3_io_d_out,
	input wire logic timer_ch3_io_c_out,
	input wire logic timer_ch3_io_b_out,
	input wire logic timer_ch3_io_a_out,
	// pulse timer capture inputs
	output logic timer_ch5_io_b_in,
	output logic timer_ch5_io_a_in,
	output logic timer_ch4_io_b_in,
	output logic timer_ch4_io_a_in,
	output logic timer_ch3_io_d_in,
	output logic timer_ch3_io_c_in,
	output logic timer_ch3_io_b_in,
	output logic timer_ch3_io_a_in
);

	// ----------------------------------------------------------------
	// state and per-pin gathering
	// ----------------------------------------------------------------
	port_b_pkg::port_state_s state;
	port_b_pkg::port_state_s next_state;

	logic [7:0] motor_enable;
	logic [7:0] motor_level;
	logic [7:0] motor_input_enable;
	logic [7:0] timer_out_mode;
	logic [7:0] timer_level;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] pin_pullup;
	logic [7:0] port_input_sel;
	logic [7:0] pin_state;
	logic [ADDR_W-1:0] word_addr;
	logic setup_phase;
	logic write_commit;

	// pin 0 has an auxiliary input instead of a motor output
	assign motor_enable = {motor_b_phase_out2_enable, motor_a_phase_out2_enable,
		motor_b_phase_out1_enable, motor_a_phase_out1_enable,
		motor_b_phase_out0_enable, motor_a_phase_out0_enable,
		motor_aux_output_enable, 1'b0};
	assign motor_level = {motor_b_phase_out2, motor_a_phase_out2,
		motor_b_phase_out1, motor_a_phase_out1,
		motor_b_phase_out0, motor_a_phase_out0,
		motor_aux_output, 1'b0};
	assign motor_input_enable = {7'h00, motor_aux_input_enable};
	assign timer_out_mode = {timer_ch5_io_b_out_mode, timer_ch5_io_a_out_mode,
		timer_ch4_io_b_out_mode, timer_ch4_io_a_out_mode,
		timer_ch3_io_d_out_mode, timer_ch3_io_c_out_mode,
		timer_ch3_io_b_out_mode, timer_ch3_io_a_out_mode};
	assign timer_level = {timer_ch5_io_b_out, timer_ch5_io_a_out,
		timer_ch4_io_b_out, timer_ch4_io_a_out,
		timer_ch3_io_d_out, timer_ch3_io_c_out,
		timer_ch3_io_b_out, timer_ch3_io_a_out};

	// ----------------------------------------------------------------
	// per-pin function mux and pad driver
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < `PORT_B_PIN_COUNT; i++) begin : g_pin
			pad_req_if req ();

			pin_select u_select (
				.motor_enable(motor_enable[i]),
				.motor_level(motor_level[i]),
				.motor_input_enable(motor_input_enable[i]),
				.timer_out_mode(timer_out_mode[i]),
				.timer_level(timer_level[i]),
				.direction(state.direction[i]),
				.output_data(state.output_data[i]),
				.output_type(state.output_type[i]),
				.pullup_enable(state.pullup_control[i]),
				.req(req.src)
			);

			pad_driver u_driver (
				.req(req.dst),
				.pad_out(pin_out[i]),
				.pad_oe(pin_oe[i]),
				.pad_pullup(pin_pullup[i])
			);

			// capture only sees the pad in port-input mode; pin-state reads go by the direction bit
			assign port_input_sel[i] = (req.func == port_b_pkg::FUNC_PORT_IN);
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin-state view
	// ----------------------------------------------------------------
	// pins with direction one read back the data register, not the pad
	assign pin_state = (state.direction & state.output_data) |
		(~state.direction & pad_in); // [R16]

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// offsets are word aligned, the low two address bits are ignored
	assign word_addr = {paddr[ADDR_W-1:2], 2'b00};
	assign setup_phase = psel & ~penable;
	assign write_commit = psel & penable & state.pready & pwrite & ~state.pslverr;

	// next-state logic for registers, bus answer and pads
	always_comb begin
		next_state = state;

		// zero wait states: pready is raised by the setup edge, dropped after access
		next_state.pready = setup_phase;
		if (setup_phase) begin
			next_state.prdata = `PORT_B_READ_ZERO;
			next_state.pslverr = 1'b0;
			case (word_addr)
				ADDR_W'(`PORT_B_DIRECTION_OFFSET): begin
					// write-only, reads as zero
					next_state.prdata = `PORT_B_READ_ZERO; // [R15]
				end
				ADDR_W'(`PORT_B_OUTPUT_DATA_OFFSET): begin
					next_state.prdata = {24'h000000, state.output_data};
				end
				ADDR_W'(`PORT_B_PIN_STATE_OFFSET): begin
					next_state.prdata = {24'h000000, pin_state}; // [R16]
					next_state.pslverr = pwrite;
				end
				ADDR_W'(`PORT_B_PULLUP_OFFSET): begin
					next_state.prdata = {24'h000000, state.pullup_control}; // [R01]
				end
				ADDR_W'(`PORT_B_OUTPUT_TYPE_OFFSET): begin
					next_state.prdata = {24'h000000, state.output_type}; // [R03]
				end
				default: begin
					// unmapped address answers with an error and zero data
					next_state.pslverr = 1'b1;
				end
			endcase
		end else begin
			// the error answer stands only as long as pready does
			next_state.pslverr = 1'b0;
		end

		// writes land only at the access edge that sees pready high
		if (write_commit) begin
			case (word_addr)
				ADDR_W'(`PORT_B_DIRECTION_OFFSET): begin
					next_state.direction = pwdata[7:0]; // [R15]
				end
				ADDR_W'(`PORT_B_OUTPUT_DATA_OFFSET): begin
					next_state.output_data = pwdata[7:0];
				end
				ADDR_W'(`PORT_B_PULLUP_OFFSET): begin
					next_state.pullup_control = pwdata[7:0]; // [R01]
				end
				ADDR_W'(`PORT_B_OUTPUT_TYPE_OFFSET): begin
					next_state.output_type = pwdata[7:0]; // [R03]
				end
				default: begin
					next_state.direction = state.direction;
				end
			endcase
		end

		// pads and timer inputs are registered so every output is a flop,
		// at the cost of one clock of latency through the mux
		next_state.pad_out = pin_out; // [R05]
		next_state.pad_oe = pin_oe; // [R04] [R14]
		next_state.pad_pullup = pin_pullup & ~pin_oe; // [R17]
		next_state.capture = pad_in & port_input_sel; // [R06] [R07] [R08] [R09]
		next_state.motor_aux_input = pad_in[0] & motor_aux_input_enable &
			~state.direction[0] & ~motor_enable[0]; // [R13]
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.direction <= `PORT_B_DIRECTION_RESET; // [R15]
			state.output_data <= `PORT_B_OUTPUT_DATA_RESET;
			state.pullup_control <= `PORT_B_PULLUP_RESET; // [R01]
			state.output_type <= `PORT_B_OUTPUT_TYPE_RESET; // [R03]
			state.prdata <= `PORT_B_READ_ZERO;
			state.pready <= 1'b0;
			state.pslverr <= 1'b0;
			state.pad_out <= 8'h00;
			state.pad_oe <= 8'h00;
			state.pad_pullup <= 8'h00;
			state.capture <= 8'h00;
			state.motor_aux_input <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign pad_out = state.pad_out;
	assign pad_oe = state.pad_oe;
	assign pad_pullup = state.pad_pullup;
	assign motor_aux_input = state.motor_aux_input;

	// capture feeds, one per pin
	assign timer_ch5_io_b_in = state.capture[7]; // [R06]
	assign timer_ch5_io_a_in = state.capture[6]; // [R07]
	assign timer_ch4_io_b_in = state.capture[5]; // [R08]
	assign timer_ch4_io_a_in = state.capture[4]; // [R09]
	assign timer_ch3_io_d_in = state.capture[3]; // [R10]
	assign timer_ch3_io_c_in = state.capture[2]; // [R11]
	assign timer_ch3_io_b_in = state.capture[1]; // [R12]
	assign timer_ch3_io_a_in = state.capture[0]; // [R13]

endmodule

// [inc/pad_req_if.sv]
// per-pin request from the function mux to the pad driver
`timescale 1ns/100ps
interface pad_req_if;
	port_b_pkg::pin_func_e func;
	logic level;
	logic open_drain;
	logic pullup_bit;

	modport src (output func, output level, output open_drain, output pullup_bit);
	modport dst (input func, input level, input open_drain, input pullup_bit);
endinterface

// [inc/port_b_defines.svh]
// register offsets, reset values and widths of the port b pad control block
`ifndef PORT_B_DEFINES_SVH
`define PORT_B_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PORT_B_DIRECTION_OFFSET 12'h000
`define PORT_B_OUTPUT_DATA_OFFSET 12'h004
`define PORT_B_PIN_STATE_OFFSET 12'h008
`define PORT_B_PULLUP_OFFSET 12'h00C
`define PORT_B_OUTPUT_TYPE_OFFSET 12'h010

// ----------------------------------------------------------------
// reset values and field widths
// ----------------------------------------------------------------
`define PORT_B_PIN_COUNT 8
`define PORT_B_DIRECTION_RESET 8'h00
`define PORT_B_OUTPUT_DATA_RESET 8'h00
`define PORT_B_PULLUP_RESET 8'h00
`define PORT_B_OUTPUT_TYPE_RESET 8'h00
`define PORT_B_READ_ZERO 32'h00000000

`endif

// [inc/port_b_pkg.sv]
// types shared by the port b pad control block
package port_b_pkg;

	// ----------------------------------------------------------------
	// pin function selected by the priority mux
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FUNC_PORT_IN = 3'b000,
		FUNC_PORT_OUT = 3'b001,
		FUNC_TIMER_OUT = 3'b010,
		FUNC_MOTOR_OUT = 3'b011,
		FUNC_MOTOR_IN = 3'b100
	} pin_func_e;

	// ----------------------------------------------------------------
	// complete state of the top module
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] direction;
		logic [7:0] output_data;
		logic [7:0] pullup_control;
		logic [7:0] output_type;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] pad_out;
		logic [7:0] pad_oe;
		logic [7:0] pad_pullup;
		logic [7:0] capture;
		logic motor_aux_input;
	} port_state_s;

endpackage

// [tb/pad_board.sv]
// board model that resolves the eight pad wires
`timescale 1ns/100ps
module pad_board (
	input wire logic pclk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_level,
	output logic [7:0] pad_in
);
	logic [7:0] float_pat = 8'h55;
	// an undriven wire without pull-up wanders, so nothing may rely on it
	always_ff @(posedge pclk) begin
		float_pat <= ~float_pat;
	end
	// the block wins over the board; the pull-up only holds an idle wire
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_level[i];
			end else if (pad_pullup[i]) begin
				pad_in[i] = 1'h1;
			end else begin
				pad_in[i] = float_pat[i];
			end
		end
	end
endmodule

// [tb/port_b_pad_control_mux_test.sv]
// testbench for the port b pad control block
`timescale 1ns/100ps
`include "port_b_defines.svh"
module port_b_pad_control_mux_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, aux_in, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, ext_en, ext_level;
	logic [7:0] tmode, tlev, menb, mlev, cap;
	int error_cnt = 0;
	int num_checks = 0;
	port_b_pad_control_mux u_port_b_pad_control_mux (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe,
		.pad_pullup, .motor_b_phase_out2_enable(menb[7]), .motor_a_phase_out2_enable(menb[6]),
		.motor_b_phase_out1_enable(menb[5]), .motor_a_phase_out1_enable(menb[4]),
		.motor_b_phase_out0_enable(menb[3]), .motor_a_phase_out0_enable(menb[2]),
		.motor_aux_output_enable(menb[1]), .motor_aux_input_enable(menb[0]),
		.motor_b_phase_out2(mlev[7]), .motor_a_phase_out2(mlev[6]),
		.motor_b_phase_out1(mlev[5]), .motor_a_phase_out1(mlev[4]),
		.motor_b_phase_out0(mlev[3]), .motor_a_phase_out0(mlev[2]),
		.motor_aux_output(mlev[1]), .motor_aux_input(aux_in),
		.timer_ch5_io_b_out_mode(tmode[7]), .timer_ch5_io_a_out_mode(tmode[6]),
		.timer_ch4_io_b_out_mode(tmode[5]), .timer_ch4_io_a_out_mode(tmode[4]),
		.timer_ch3_io_d_out_mode(tmode[3]), .timer_ch3_io_c_out_mode(tmode[2]),
		.timer_ch3_io_b_out_mode(tmode[1]), .timer_ch3_io_a_out_mode(tmode[0]),
		.timer_ch5_io_b_out(tlev[7]), .timer_ch5_io_a_out(tlev[6]),
		.timer_ch4_io_b_out(tlev[5]), .timer_ch4_io_a_out(tlev[4]),
		.timer_ch3_io_d_out(tlev[3]), .timer_ch3_io_c_out(tlev[2]),
		.timer_ch3_io_b_out(tlev[1]), .timer_ch3_io_a_out(tlev[0]),
		.timer_ch5_io_b_in(cap[7]), .timer_ch5_io_a_in(cap[6]), .timer_ch4_io_b_in(cap[5]),
		.timer_ch4_io_a_in(cap[4]), .timer_ch3_io_d_in(cap[3]), .timer_ch3_io_c_in(cap[2]),
		.timer_ch3_io_b_in(cap[1]), .timer_ch3_io_a_in(cap[0]));
	pad_board u_pad_board (.pclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_level, .pad_in);
	// ----------------------------------------------------------------
	// clock, verdict and compare helpers
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			error_cnt++;
			final_report();
		end
		// one idle edge, so a following call never re-raises psel in this time step
		@(posedge pclk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_en, ext_level, tmode, tlev, menb, mlev} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(0, `PORT_B_PULLUP_OFFSET, 0);
		check(rd_data, `PORT_B_PULLUP_RESET);
		apb(0, `PORT_B_OUTPUT_TYPE_OFFSET, 0);
		check(rd_data, `PORT_B_OUTPUT_TYPE_RESET);
		apb(0, `PORT_B_DIRECTION_OFFSET, 0);
		check(rd_data, 0);
		ext_en <= 8'hFF;
		ext_level <= 8'hA5;
		repeat (3) @(posedge pclk);
		check(cap, 8'hA5);
		check(pad_oe, 8'h00);
		apb(0, `PORT_B_PIN_STATE_OFFSET, 0);
		check(rd_data, 8'hA5);
		// upper data bits are dropped on write
		apb(1, `PORT_B_PULLUP_OFFSET, 32'hFFFFFFFF);
		apb(0, `PORT_B_PULLUP_OFFSET, 0);
		check(rd_data, 8'hFF);
		ext_en <= 8'h00;
		repeat (3) @(posedge pclk);
		check(pad_pullup, 8'hFF);
		// low nibble outputs, pins 1 and 0 open-drain
		apb(1, `PORT_B_OUTPUT_TYPE_OFFSET, 8'h03);
		apb(0, `PORT_B_OUTPUT_TYPE_OFFSET, 0);
		check(rd_data, 8'h03);
		apb(1, `PORT_B_OUTPUT_DATA_OFFSET, 8'h05);
		apb(1, `PORT_B_DIRECTION_OFFSET, 8'h0F);
		ext_en <= 8'hF0;
		ext_level <= 8'hA0;
		repeat (3) @(posedge pclk);
		check(pad_oe, 8'h0E);
		check(pad_out, 8'h04);
		check(pad_pullup, 8'hF0);
		apb(0, `PORT_B_PIN_STATE_OFFSET, 0);
		check(rd_data, 8'hA5);
		apb(1, `PORT_B_PIN_STATE_OFFSET, 8'hFF);
		check(rd_err, 1'h1);
		apb(0, 12'h020, 0);
		check(rd_err, 1'h1);
		check(rd_data, `PORT_B_READ_ZERO);
		// timer beats port, motor beats timer, on pins 1 up to 7
		for (int i = 1; i < 8; i++) begin
			tmode[i] <= 1'h1;
			tlev[i] <= 1'h1;
			repeat (2) @(posedge pclk);
			check({pad_oe[i], pad_out[i], pad_pullup[i]}, 3'h6);
			menb[i] <= 1'h1;
			repeat (2) @(posedge pclk);
			check({pad_oe[i], pad_out[i]}, 2'h2);
		end
		// pin 0: auxiliary input wins over the timer while direction is 0
		apb(1, `PORT_B_DIRECTION_OFFSET, 0);
		ext_en <= 8'h01;
		ext_level <= 8'h01;
		menb[0] <= 1'h1;
		tmode[0] <= 1'h1;
		tlev[0] <= 1'h1;
		repeat (3) @(posedge pclk);
		check({aux_in, pad_oe[0]}, 2'h2);
		menb[0] <= 1'h0;
		repeat (2) @(posedge pclk);
		check({aux_in, pad_oe[0], pad_out[0]}, 3'h3);
		// a second reset in mid-run must clear what software wrote
		{menb, tmode} <= '0;
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		check(pad_oe, 8'h00);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(0, `PORT_B_PULLUP_OFFSET, 0);
		check(rd_data, `PORT_B_PULLUP_RESET);
		apb(0, `PORT_B_OUTPUT_TYPE_OFFSET, 0);
		check(rd_data, `PORT_B_OUTPUT_TYPE_RESET);
		final_report();
	end
endmodule

// [tb/port_b_props.sv]
// assertion checker for the port b pad control block
`timescale 1ns/100ps
module port_b_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic motor_b_phase_out2_enable,
	input wire logic motor_b_phase_out2,
	input wire logic motor_a_phase_out2_enable,
	input wire logic timer_ch5_io_a_out_mode,
	input wire logic timer_ch5_io_a_out,
	input wire logic motor_aux_output_enable,
	input wire logic motor_aux_output,
	input wire logic motor_aux_input_enable,
	input wire logic motor_aux_input,
	input wire logic timer_ch3_io_d_in
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// apb handshake and pad mux relations
	// ----------------------------------------------------------------
	sequence apb_setup_s;
		psel && !penable;
	endsequence
	sequence apb_access_s;
		pready ##1 !pready;
	endsequence
	ready_after_setup_a: assert property (apb_setup_s |=> apb_access_s)
		else $error("pready missing in access cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	pullup_oe_excl_a: assert property ((pad_pullup & pad_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	motor_pin7_a: assert property (motor_b_phase_out2_enable |=>
		pad_oe[7] && pad_out[7] == $past(motor_b_phase_out2))
		else $error("pin 7 not driven by motor");
	timer_pin6_a: assert property (!motor_a_phase_out2_enable && timer_ch5_io_a_out_mode |=>
		pad_oe[6] && pad_out[6] == $past(timer_ch5_io_a_out))
		else $error("pin 6 not driven by timer");
	motor_pin1_a: assert property (motor_aux_output_enable |=>
		pad_oe[1] && pad_out[1] == $past(motor_aux_output))
		else $error("pin 1 not driven by motor");
	aux_in_off_a: assert property (!motor_aux_input_enable |=> !motor_aux_input)
		else $error("aux input active while disabled");
	aux_in_level_a: assert property (motor_aux_input |->
		$past(pad_in[0]) && !pad_oe[0])
		else $error("aux input not from pin 0");
	capture_pin3_a: assert property (timer_ch3_io_d_in |-> !pad_oe[3] && $past(pad_in[3]))
		else $error("capture d not from pin 3");
endmodule
bind port_b_pad_control_mux port_b_props u_props (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .pad_in, .pad_out, .pad_oe, .pad_pullup, .motor_b_phase_out2_enable,
	.motor_b_phase_out2, .motor_a_phase_out2_enable, .timer_ch5_io_a_out_mode,
	.timer_ch5_io_a_out, .motor_aux_output_enable, .motor_aux_output,
	.motor_aux_input_enable, .motor_aux_input, .timer_ch3_io_d_in);
